/* File: rtl/bsm_pkg.sv */
// Shared constants for the pressure sensor target and its bus controller
package bsm_pkg;
  // Target address and register map of the sensor
  localparam logic [6:0] DEF_TARGET_ADDR = 7'h78;
  localparam logic [7:0] REG_P_HI        = 8'h06;
  localparam logic [7:0] REG_P_MID       = 8'h07;
  localparam logic [7:0] REG_P_LO        = 8'h08;
  localparam logic [7:0] REG_T_HI        = 8'h09;
  localparam logic [7:0] REG_T_LO        = 8'h0A;
  localparam logic [7:0] REG_STATUS      = 8'h20;
  localparam logic [7:0] REG_CTRL        = 8'h30;
  localparam logic [7:0] RESULT_RESET    = 8'h00;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  // Control and status fields
  localparam int         CTRL_SLEEP_LSB  = 4;
  localparam int         CTRL_ACTIVE_BIT = 3;
  localparam int         STATUS_DONE_BIT = 0;
  localparam logic [2:0] MODE_SINGLE_T   = 3'h0;
  localparam logic [2:0] MODE_SINGLE_P   = 3'h1;
  localparam logic [2:0] MODE_P_THEN_T   = 3'h2;
  localparam logic [2:0] MODE_SLEEP      = 3'h3;
  // Timing: sleep interval is (code + 1) steps of 62.5 ms
  localparam int         CLK_PERIOD_NS   = 8;
  localparam int         SLEEP_STEP_US   = 62500;
  localparam int         SLEEP_STEP_CYC  = SLEEP_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam int         CONV_CYC_DEF    = 64;
  localparam int         BYTE_BITS       = 8;
  // Controller bus rate and quarter bit period, rounded up
  localparam int         I2C_RATE_KHZ    = 100;
  localparam int         QTR_DIV         = I2C_RATE_KHZ * CLK_PERIOD_NS * 4;
  localparam int         SCL_QTR_CYC     = (1000000 + QTR_DIV - 1) / QTR_DIV;
  // Controller register map (Avalon byte addresses) and fields
  localparam logic [3:0] HOST_CMD        = 4'h0;
  localparam logic [3:0] HOST_STATUS     = 4'h4;
  localparam logic [3:0] HOST_RDATA      = 4'h8;
  localparam logic [3:0] HOST_TARGET     = 4'hC;
  localparam int         CMD_PTR_LSB     = 0;
  localparam int         CMD_DATA_LSB    = 8;
  localparam int         CMD_READ_BIT    = 16;
  localparam int         CMD_NBYTES_LSB  = 17;
  localparam int         STAT_BUSY_BIT   = 0;
  localparam int         STAT_NACK_BIT   = 1;
  // Controller sequence operations
  localparam logic [1:0] OP_ST           = 2'h0;
  localparam logic [1:0] OP_WB           = 2'h1;
  localparam logic [1:0] OP_RB           = 2'h2;
  localparam logic [1:0] OP_SP           = 2'h3;
endpackage

/* File: rtl/bsm_i2c_if.sv */
// Two-wire bus between the sensor target and the controller
`timescale 1ns/100ps
`default_nettype none
interface bsm_i2c_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Pull-ups hold both lines high unless someone drives low
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
                output host_sda_oe, input scl, input sda);
  modport device (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

/* File: rtl/bsm_sensor.sv */
// Sensor end: bus target, register file and measurement sequencer
//
// Chosen here: the two-wire bus target port.
`timescale 1ns/100ps
`default_nettype none
module bsm_sensor
  import bsm_pkg::*;
#(
  parameter int SLEEP_CYC = SLEEP_STEP_CYC,
  parameter int CONV_CYC  = CONV_CYC_DEF
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Bus
  bsm_i2c_if.device        bus,
  // Address programming
  input  wire logic        otp_addr_valid_i,
  input  wire logic [6:0]  otp_addr_i,
  // Converter data and selects
  input  wire logic        raw_p_sel_i,
  input  wire logic        raw_t_sel_i,
  input  wire logic [23:0] p_raw_i,
  input  wire logic [23:0] p_cal_i,
  input  wire logic [15:0] t_raw_i,
  input  wire logic [15:0] t_cal_i,
  // Status
  output logic             collection_active_o,
  output logic             conv_done_o
);
  typedef enum logic [7:0] {
    D_IDLE = 8'b0000_0001, D_ADDR = 8'b0000_0010, D_ACK_A = 8'b0000_0100,
    D_WR   = 8'b0000_1000, D_ACK_W = 8'b0001_0000, D_RD = 8'b0010_0000,
    D_MACK = 8'b0100_0000, D_IGN  = 8'b1000_0000
  } bsm_dev_e;
  typedef enum logic [3:0] {
    M_IDLE = 4'b0001, M_CONV_P = 4'b0010, M_CONV_T = 4'b0100, M_SLEEP = 4'b1000
  } bsm_meas_e;
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam int SW = $clog2(SLEEP_CYC + 1);

  logic [2:0]  scl_sy_q, sda_sy_q;
  logic        scl_f_q, sda_f_q, scl_new, sda_new;
  logic        scl_rise, scl_fall, start_ev, stop_ev;
  bsm_dev_e    st_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q, tx_q, ptr_q, rd_mux;
  logic        rw_q, first_q, sda_oe_q;
  logic        wr_done, rd_load, ctrl_wr, stat_rd;
  logic [6:0]  own_addr;
  bsm_meas_e   ms_q;
  logic [2:0]  mode_q;
  logic [3:0]  sleep_code_q, unit_q;
  logic [CW-1:0] conv_q;
  logic [SW-1:0] step_q;
  logic        done_q, done_set, conv_end, step_end;
  logic [23:0] p_res_q;
  logic [15:0] t_res_q;

  // Three-stage sampling; a level counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      scl_f_q  <= 1'b1;
      sda_f_q  <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[1:0], bus.scl};
      sda_sy_q <= {sda_sy_q[1:0], bus.sda};
      scl_f_q  <= scl_new;
      sda_f_q  <= sda_new;
    end
  end
  assign scl_new  = (scl_sy_q[2] == scl_sy_q[1]) ? scl_sy_q[1] : scl_f_q;
  assign sda_new  = (sda_sy_q[2] == sda_sy_q[1]) ? sda_sy_q[1] : sda_f_q;
  assign scl_rise = scl_new & ~scl_f_q;
  assign scl_fall = ~scl_new & scl_f_q;
  // Data moving while the clock is high marks start or stop
  assign start_ev = scl_f_q & scl_new & sda_f_q & ~sda_new;
  assign stop_ev  = scl_f_q & scl_new & ~sda_f_q & sda_new;

  assign own_addr = otp_addr_valid_i ? otp_addr_i : DEF_TARGET_ADDR;
  assign wr_done  = scl_fall & (st_q == D_WR) & (cnt_q == 4'(BYTE_BITS));
  assign rd_load  = scl_fall & (((st_q == D_ACK_A) & rw_q) | (st_q == D_MACK));
  assign ctrl_wr  = wr_done & ~first_q & (ptr_q == REG_CTRL);
  assign stat_rd  = rd_load & (ptr_q == REG_STATUS);

  always_comb begin
    unique case (ptr_q)
      REG_P_HI:   rd_mux = p_res_q[23:16];
      REG_P_MID:  rd_mux = p_res_q[15:8];
      REG_P_LO:   rd_mux = p_res_q[7:0];
      REG_T_HI:   rd_mux = t_res_q[15:8];
      REG_T_LO:   rd_mux = t_res_q[7:0];
      REG_STATUS: rd_mux = {7'h00, done_q};
      REG_CTRL:   rd_mux = {sleep_code_q, collection_active_o, mode_q};
      default:    rd_mux = 8'h00;
    endcase
  end

  // Bus target; drives data only after a clock fall
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q     <= D_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      rw_q     <= 1'b0;
      first_q  <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_ev) begin
      st_q     <= D_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start_ev) begin
      st_q     <= D_ADDR;
      cnt_q    <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == D_ADDR || st_q == D_WR) begin
        sh_q  <= {sh_q[6:0], sda_f_q};
        cnt_q <= cnt_q + 4'h1;
      end else if (st_q == D_RD) begin
        cnt_q <= cnt_q + 4'h1;
      end else if (st_q == D_MACK && sda_f_q) begin
        st_q <= D_IGN;  // Host refused the byte: it was the last
      end
    end else if (scl_fall) begin
      unique case (st_q)
        D_ADDR: if (cnt_q == 4'(BYTE_BITS)) begin
          if (sh_q[7:1] == own_addr) begin
            sda_oe_q <= 1'b1;
            rw_q     <= sh_q[0];
            st_q     <= D_ACK_A;
          end else begin
            st_q <= D_IGN;
          end
        end
        D_ACK_A: begin
          cnt_q   <= 4'h0;
          first_q <= 1'b1;
          if (rw_q) begin
            tx_q     <= rd_mux;
            sda_oe_q <= ~rd_mux[7];
            st_q     <= D_RD;
          end else begin
            sda_oe_q <= 1'b0;
            st_q     <= D_WR;
          end
        end
        D_WR: if (cnt_q == 4'(BYTE_BITS)) begin
          sda_oe_q <= 1'b1;
          st_q     <= D_ACK_W;
        end
        D_ACK_W: begin
          sda_oe_q <= 1'b0;
          first_q  <= 1'b0;
          cnt_q    <= 4'h0;
          st_q     <= D_WR;
        end
        D_RD: if (cnt_q == 4'(BYTE_BITS)) begin
          sda_oe_q <= 1'b0;  // Acknowledge slot is the host's
          st_q     <= D_MACK;
        end else begin
          tx_q     <= {tx_q[6:0], 1'b0};
          sda_oe_q <= ~tx_q[6];
        end
        D_MACK: begin
          tx_q     <= rd_mux;
          sda_oe_q <= ~rd_mux[7];
          cnt_q    <= 4'h0;
          st_q     <= D_RD;
        end
        default: ;
      endcase
    end
  end

  // Register pointer: first written byte loads it, every later data byte moves it on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= 8'h00;
    end else if (wr_done && first_q) begin
      ptr_q <= sh_q;
    end else if (wr_done || rd_load) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  assign conv_end = (conv_q == CW'(CONV_CYC - 1));
  assign step_end = (step_q == SW'(SLEEP_CYC - 1));
  assign done_set = conv_end & (ms_q == M_CONV_T || (ms_q == M_CONV_P && mode_q == MODE_SINGLE_P));

  // Measurement sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_q         <= M_IDLE;
      mode_q       <= CTRL_RESET[2:0];
      sleep_code_q <= CTRL_RESET[7:CTRL_SLEEP_LSB];
      conv_q       <= '0;
      step_q       <= '0;
      unit_q       <= 4'h0;
    end else if (ctrl_wr) begin
      mode_q       <= sh_q[2:0];
      sleep_code_q <= sh_q[7:CTRL_SLEEP_LSB];
      conv_q       <= '0;
      unique case (sh_q[2:0])
        MODE_SINGLE_T: ms_q <= M_CONV_T;
        MODE_SINGLE_P, MODE_P_THEN_T, MODE_SLEEP: ms_q <= M_CONV_P;
        default: ms_q <= M_IDLE;
      endcase
    end else begin
      unique case (ms_q)
        M_CONV_P, M_CONV_T: begin
          conv_q <= conv_end ? '0 : conv_q + CW'(1);
          if (conv_end) begin
            if (ms_q == M_CONV_P) begin
              ms_q <= (mode_q == MODE_SINGLE_P) ? M_IDLE : M_CONV_T;
            end else if (mode_q == MODE_SLEEP) begin
              ms_q   <= M_SLEEP;
              step_q <= '0;
              unit_q <= 4'h0;
            end else begin
              ms_q <= M_IDLE;
            end
          end
        end
        M_SLEEP: begin
          step_q <= step_end ? '0 : step_q + SW'(1);
          if (step_end) begin
            unit_q <= unit_q + 4'h1;
            if (unit_q == sleep_code_q) begin
              ms_q <= M_CONV_P;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Results latch at the end of each conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_res_q <= {3{RESULT_RESET}};
      t_res_q <= {2{RESULT_RESET}};
    end else if (conv_end && ms_q == M_CONV_P) begin
      p_res_q <= raw_p_sel_i ? p_raw_i : p_cal_i;
    end else if (conv_end && ms_q == M_CONV_T) begin
      t_res_q <= raw_t_sel_i ? t_raw_i : t_cal_i;
    end
  end

  // Done flag: completion wins over the clear from a status read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1;
    end else if (stat_rd || ctrl_wr) begin
      done_q <= 1'b0;
    end
  end

  assign collection_active_o = (ms_q == M_CONV_P) | (ms_q == M_CONV_T);
  assign conv_done_o         = done_q;
  assign bus.dev_sda_o       = 1'b0;
  assign bus.dev_sda_oe      = sda_oe_q;
endmodule
`default_nettype wire

/* File: rtl/bsm_host.sv */
// Controller end: Avalon-MM command registers and bus sequencer
`timescale 1ns/100ps
`default_nettype none
module bsm_host
  import bsm_pkg::*;
#(
  parameter int QTR_CYC = SCL_QTR_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Bus
  bsm_i2c_if.host          bus
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_START = 4'b0010, H_BIT = 4'b0100, H_STOP = 4'b1000
  } bsm_host_e;
  localparam int DW = $clog2(QTR_CYC + 1);

  bsm_host_e   ph_q;
  logic [DW-1:0] div_q;
  logic [1:0]  qtr_q, nb_q, op_c, op_n;
  logic [3:0]  step_q, bit_q;
  logic [7:0]  sh_q, ptr_q, wdat_q, byte_n;
  logic [6:0]  target_q;
  logic [23:0] rdata_q;
  logic [2:0]  sda_sy_q;
  logic        sda_f_q, busy_q, nack_q, abort_q, rd_q, scl_q, sdal_q, tick;
  logic        rvalid_q, cmd_go, last_rb, final_c, wr_ok;

  function automatic logic [1:0] op_f(input logic [3:0] s, input logic rd,
                                      input logic [1:0] n, input logic ab);
    logic [1:0] op;
    op = OP_WB;
    if (ab) op = OP_SP;
    else if (s == 4'h0 || (rd && s == 4'h4)) op = OP_ST;
    else if ((!rd && s == 4'h4) || (rd && s == 4'h3)) op = OP_SP;
    else if (rd && s >= 4'h6) op = (s < 4'h6 + {2'h0, n}) ? OP_RB : OP_SP;
    return op;
  endfunction

  function automatic bsm_host_e ph_f(input logic [1:0] op);
    bsm_host_e p;
    p = H_BIT;
    if (op == OP_ST) p = H_START;
    if (op == OP_SP) p = H_STOP;
    return p;
  endfunction

  assign op_c    = op_f(step_q, rd_q, nb_q, abort_q);
  assign op_n    = op_f(step_q + 4'h1, rd_q, nb_q, abort_q);
  assign final_c = abort_q | ~(rd_q & (step_q == 4'h3));
  assign last_rb = (step_q == 4'h5 + {2'h0, nb_q});
  assign tick    = busy_q & (div_q == DW'(QTR_CYC - 1));
  // Byte for the step about to begin, loaded as the current step ends
  always_comb begin
    unique case (4'(step_q + 4'h1))
      4'h1:    byte_n = {target_q, 1'b0};
      4'h2:    byte_n = ptr_q;
      4'h3:    byte_n = wdat_q;
      default: byte_n = {target_q, 1'b1};
    endcase
  end

  // Avalon: reads take one wait cycle, commands wait while busy
  assign cmd_go = avs_write_i & (avs_address_i == HOST_CMD);
  assign avs_waitrequest_o = (avs_read_i & ~rvalid_q) | (cmd_go & busy_q);
  assign wr_ok  = avs_write_i & ~avs_waitrequest_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_q       <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      rvalid_q <= avs_read_i & ~rvalid_q;
      if (avs_read_i && !rvalid_q) begin
        unique case (avs_address_i)
          HOST_STATUS: avs_readdata_o <= {30'h0, nack_q, busy_q};
          HOST_RDATA:  avs_readdata_o <= {8'h00, rdata_q};
          HOST_TARGET: avs_readdata_o <= {25'h0, target_q};
          default:     avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_q <= DEF_TARGET_ADDR;
    end else if (wr_ok && avs_address_i == HOST_TARGET) begin
      target_q <= avs_writedata_i[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_sy_q <= 3'h7;
      sda_f_q  <= 1'b1;
    end else begin
      sda_sy_q <= {sda_sy_q[1:0], bus.sda};
      if (sda_sy_q[2] == sda_sy_q[1]) sda_f_q <= sda_sy_q[1];
    end
  end

  // Sequencer: four quarters per bit, clock always driven here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q <= H_IDLE;
      div_q <= '0;
      qtr_q <= 2'h0;
      step_q <= 4'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      wdat_q <= 8'h00;
      nb_q <= 2'h1;
      rd_q <= 1'b0;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      abort_q <= 1'b0;
      rdata_q <= 24'h0;
      scl_q <= 1'b1;
      sdal_q <= 1'b0;
    end else if (wr_ok && cmd_go) begin
      ptr_q   <= avs_writedata_i[CMD_PTR_LSB +: 8];
      wdat_q  <= avs_writedata_i[CMD_DATA_LSB +: 8];
      rd_q    <= avs_writedata_i[CMD_READ_BIT];
      nb_q    <= (avs_writedata_i[CMD_NBYTES_LSB +: 2] == 2'h0) ? 2'h1
                 : avs_writedata_i[CMD_NBYTES_LSB +: 2];
      busy_q  <= 1'b1;
      nack_q  <= 1'b0;
      abort_q <= 1'b0;
      step_q  <= 4'h0;
      ph_q    <= H_START;
      qtr_q   <= 2'h0;
      div_q   <= '0;
    end else if (busy_q) begin
      div_q <= tick ? '0 : div_q + DW'(1);
      if (tick) begin
        qtr_q <= qtr_q + 2'h1;
        unique case (ph_q)
          H_START: begin
            if (qtr_q == 2'h0) sdal_q <= 1'b0;
            if (qtr_q == 2'h1) scl_q <= 1'b1;
            if (qtr_q == 2'h2) sdal_q <= 1'b1;
            if (qtr_q == 2'h3) begin
              scl_q  <= 1'b0;
              step_q <= step_q + 4'h1;
              ph_q   <= ph_f(op_n);
              bit_q  <= 4'h0;
              sh_q   <= byte_n;
            end
          end
          H_BIT: begin
            if (qtr_q == 2'h0) begin
              // Data set only with the clock low
              if (bit_q == 4'(BYTE_BITS)) sdal_q <= (op_c == OP_RB) & ~last_rb;
              else sdal_q <= (op_c == OP_WB) & ~sh_q[7];
            end
            if (qtr_q == 2'h1) scl_q <= 1'b1;
            if (qtr_q == 2'h2) begin
              if (bit_q == 4'(BYTE_BITS) && op_c == OP_WB && sda_f_q) begin
                nack_q  <= 1'b1;
                abort_q <= 1'b1;
              end
              if (bit_q < 4'(BYTE_BITS) && op_c == OP_RB) rdata_q <= {rdata_q[22:0], sda_f_q};
            end
            if (qtr_q == 2'h3) begin
              scl_q <= 1'b0;
              sh_q  <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              // Acknowledge level stays until the next quarter zero, clock low
              if (bit_q == 4'(BYTE_BITS)) begin
                step_q <= step_q + 4'h1;
                ph_q   <= ph_f(op_n);
                bit_q  <= 4'h0;
                sh_q   <= byte_n;
              end
            end
          end
          H_STOP: begin
            if (qtr_q == 2'h0) sdal_q <= 1'b1;
            if (qtr_q == 2'h1) scl_q <= 1'b1;
            if (qtr_q == 2'h2) sdal_q <= 1'b0;
            if (qtr_q == 2'h3) begin
              if (final_c) begin
                busy_q <= 1'b0;
                ph_q   <= H_IDLE;
              end else begin
                step_q <= step_q + 4'h1;
                ph_q   <= ph_f(op_n);
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign bus.host_scl_o  = scl_q;
  assign bus.host_scl_oe = 1'b1;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = sdal_q;
endmodule
`default_nettype wire

/* File: tb/bsm_bus_asserts.sv */
// Assertions on the two-wire bus between controller and sensor
`timescale 1ns/100ps
`default_nettype none
module bsm_bus_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus drivers and resolved wires
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_scl_edge_quiet: assert property ($changed(scl) |-> $stable(sda))
    else $error("data moved with a clock edge");
  a_start_host_only: assert property (scl && $past(scl) && $fell(sda) |-> !dev_sda_oe)
    else $error("sensor holds data at start");
  a_dev_grab_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("sensor takes data in clock high");
  a_dev_drop_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("sensor frees data in clock high");
  a_dev_release_bound: assert property ($rose(dev_sda_oe) |-> ##[1:400] !dev_sda_oe)
    else $error("sensor holds data too long");
  a_scl_high_span: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase short");
  a_scl_low_span: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase short");
  a_sda_hold_high: assert property ($rose(scl) |-> $stable(sda) [*4])
    else $error("data moved in clock high");
endmodule
`default_nettype wire

/* File: tb/baro_sensor_measure_ctrl_tb.sv */
// Bench joining the sensor target and its bus controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module baro_sensor_measure_ctrl_tb
  import bsm_pkg::*;
;
  localparam int SLP  = 200;
  localparam int CONV = 2000;
  typedef struct packed {
    logic [2:0]  md;
    logic        rp;
    logic [23:0] pc;
    logic [15:0] tc;
    logic [23:0] ep;
    logic [15:0] et;
  } bsm_row_s;
  bsm_row_s    rows [3] = '{
    '{MODE_P_THEN_T, 1'b1, 24'h123456, 16'h8421, 24'h9ABCDE, 16'h8421},
    '{MODE_SINGLE_P, 1'b0, 24'h654321, 16'h1111, 24'h654321, 16'h8421},
    '{MODE_SINGLE_T, 1'b1, 24'h000001, 16'h7FFF, 24'h654321, 16'h7FFF}};
  logic [3:0]  codes [2] = '{4'h0, 4'hF};
  logic        clk_i;
  logic        rst_i;
  logic [3:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        otp_addr_valid_i;
  logic        raw_p_sel_i;
  logic [23:0] p_cal_i;
  logic [15:0] t_cal_i;
  logic        collection_active_o;
  logic        conv_done_o;
  logic [31:0] rd;
  logic [31:0] st;
  int          err_total;
  int          compares;
  int          t0;

  bsm_i2c_if bsm_i2c_if_inst ();
  bsm_sensor #(.SLEEP_CYC(SLP), .CONV_CYC(CONV)) bsm_sensor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .bus(bsm_i2c_if_inst.device),
    .otp_addr_valid_i(otp_addr_valid_i), .otp_addr_i(7'h55),
    .raw_p_sel_i(raw_p_sel_i), .raw_t_sel_i(1'b0), .p_raw_i(24'h9ABCDE),
    .p_cal_i(p_cal_i), .t_raw_i(16'hF00D), .t_cal_i(t_cal_i),
    .collection_active_o(collection_active_o), .conv_done_o(conv_done_o));
  bsm_host #(.QTR_CYC(8)) bsm_host_inst (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .bus(bsm_i2c_if_inst.host));
  bsm_bus_asserts bsm_bus_asserts_inst (
    .clk_i(clk_i), .rst_i(rst_i), .host_scl_oe(bsm_i2c_if_inst.host_scl_oe),
    .host_sda_o(bsm_i2c_if_inst.host_sda_o), .dev_sda_o(bsm_i2c_if_inst.dev_sda_o),
    .dev_sda_oe(bsm_i2c_if_inst.dev_sda_oe), .scl(bsm_i2c_if_inst.scl),
    .sda(bsm_i2c_if_inst.sda));

  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    // Request holds until the rising edge that sees waitrequest low
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  // One bus sequence, then wait until the controller is idle
  task automatic op(input logic [7:0] p, input logic [7:0] d, input logic r,
                    input logic [1:0] nb);
    av(1'b1, HOST_CMD, {13'h0, nb, r, d, p}, rd);
    do av(1'b0, HOST_STATUS, 32'h0, st); while (st[STAT_BUSY_BIT] !== 1'b0);
    av(1'b0, HOST_RDATA, 32'h0, rd);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Watchdog, well beyond the whole sequence
  initial begin
    #800000;
    err_total++;
    complete_run();
  end

  initial begin
    rst_i = 1'b1;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    otp_addr_valid_i = 1'b0;
    raw_p_sel_i = 1'b0;
    p_cal_i = 24'h0;
    t_cal_i = 16'h0;
    err_total = 0;
    compares = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      raw_p_sel_i <= rows[i].rp;
      p_cal_i     <= rows[i].pc;
      t_cal_i     <= rows[i].tc;
      op(REG_CTRL, {5'h00, rows[i].md}, 1'b0, 2'd1);
      `CHK("active", 1'b1, collection_active_o)
      op(REG_STATUS, 8'h00, 1'b1, 2'd1);
      `CHK("early done", 1'b0, rd[STATUS_DONE_BIT])
      wait (conv_done_o === 1'b1);
      @(posedge clk_i);
      `CHK("active end", 1'b0, collection_active_o)
      op(REG_STATUS, 8'h00, 1'b1, 2'd1);
      `CHK("done", 1'b1, rd[STATUS_DONE_BIT])
      op(REG_STATUS, 8'h00, 1'b1, 2'd1);
      `CHK("done clear", 1'b0, rd[STATUS_DONE_BIT])
      op(REG_CTRL, 8'h00, 1'b1, 2'd1);
      `CHK("control", {5'h00, rows[i].md}, rd[7:0])
      op(REG_P_HI, 8'h00, 1'b1, 2'd3);
      `CHK("pressure", rows[i].ep, rd[23:0])
      op(REG_T_HI, 8'h00, 1'b1, 2'd2);
      `CHK("temperature", rows[i].et, rd[15:0])
    end
    // Sleep interval boundaries, counted between repeated acquisitions
    foreach (codes[k]) begin
      op(REG_CTRL, {codes[k], 1'b0, MODE_SLEEP}, 1'b0, 2'd1);
      wait (collection_active_o === 1'b0);
      t0 = 0;
      while (collection_active_o !== 1'b1) begin
        @(posedge clk_i);
        t0++;
      end
      `CHK("sleep gap", 1'b1, t0 >= (codes[k] + 1) * SLP - 1 && t0 <= (codes[k] + 1) * SLP + 2)
    end
    op(REG_CTRL, 8'h04, 1'b0, 2'd1);
    // Foreign address must be ignored
    av(1'b1, HOST_TARGET, 32'h55, rd);
    op(REG_CTRL, 8'h01, 1'b0, 2'd1);
    `CHK("nack", 1'b1, st[STAT_NACK_BIT])
    otp_addr_valid_i <= 1'b1;
    op(REG_CTRL, 8'h00, 1'b1, 2'd1);
    `CHK("new address", 1'b0, st[STAT_NACK_BIT])
    `CHK("control kept", 8'h04, rd[7:0])
    otp_addr_valid_i <= 1'b0;
    av(1'b0, 4'h2, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    // Reset in mid-run restores defaults
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("sda idle", 1'b1, bsm_i2c_if_inst.sda)
    op(REG_P_HI, 8'h00, 1'b1, 2'd3);
    `CHK("pressure reset", 24'h0, rd[23:0])
    op(REG_T_HI, 8'h00, 1'b1, 2'd2);
    `CHK("temperature reset", 16'h0, rd[15:0])
    complete_run();
  end
endmodule
`default_nettype wire
